// ==== verilog/c2pm_pin_mux.sv ====
// Purpose: Channel 2 add-bus pin sharing, general output and line data capture
// Assumes: APB slave on pclk; add-bus and line clocks are separate domains
// Notes:   Zero wait state APB; unmapped index answers with pslverr
//
// Behaviour
// - Pin function follows telecom bus enable
// - Pin one is add-bus data bit 1
// - Pin two is add-bus data bit 2
// - Add-bus bits captured on add clock falling edge
// - Disabled: pin one drives general output bit
// - Disabled: pin two is line data, falling edge
// - Clock invert bit moves capture to rising edge
// - STS-1 mode always captures on falling edge
`timescale 1ns/100ps
`include "c2pm_map.svh"

module c2pm_pin_mux
  import c2pm_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              add_bus_clock_ch2,
  input  wire logic [7:3]        add_bus_data_ch2_hi,
  input  wire logic              add_bus_data_ch2_0,
  input  wire logic              add_bus_data_ch2_1_i,
  output logic                   add_bus_data_ch2_1_o,
  output logic                   add_bus_data_ch2_1_oe,
  input  wire logic              add_bus_data_ch2_2,
  input  wire logic              line_clock_in_ch2,
  output logic      [7:0]        add_bus_word_ch2,
  output logic                   line_data_ch2
);

  generate
    if (ADDR_W < `C2PM_MIN_ADDR_W) begin : g_addr_chk
      $error("ADDR_W too small for register indices");
    end
  endgenerate

  // APB domain
  c2pm_apb_st_t st;
  c2pm_apb_st_t next_st;
  logic [15:0]  reg_idx;
  logic         hit;
  logic         setup;
  logic         access;
  logic         wr;
  c2pm_pin_fn_t pin_fn;

  assign reg_idx = paddr[17:2];
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign hit     = (reg_idx == `C2PM_IO_CTL_IDX) || (reg_idx == `C2PM_DRIVE_IDX) ||
                   (reg_idx == `C2PM_CFG_IDX) || (reg_idx == `C2PM_STAT_IDX);
  assign wr      = access & pwrite & pstrb[0] & hit;
  assign pin_fn  = st.cfg[`C2PM_CFG_BUS_EN_BIT] ? C2PM_FN_BUS : C2PM_FN_ALT;

  always_comb begin
    next_st = st;
    next_st.line_sync = {st.line_sync[0], line_data_ch2};
    if (setup) begin
      next_st.err    = ~hit;
      next_st.prdata = 32'h0000_0000;
      if (!pwrite) begin
        case (reg_idx)
          `C2PM_IO_CTL_IDX: next_st.prdata = {24'h00_0000, st.io_ctl};
          `C2PM_DRIVE_IDX:  next_st.prdata = {24'h00_0000, st.drive};
          `C2PM_CFG_IDX:    next_st.prdata = {30'h0000_0000, st.cfg};
          `C2PM_STAT_IDX: begin
            next_st.prdata = {29'h0000_0000, add_bus_data_ch2_1_o,
                              add_bus_data_ch2_1_oe, st.line_sync[1]};
          end
          default:          next_st.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr) begin
      case (reg_idx)
        `C2PM_IO_CTL_IDX: next_st.io_ctl = pwdata[7:0];
        `C2PM_DRIVE_IDX:  next_st.drive  = pwdata[7:0];
        `C2PM_CFG_IDX:    next_st.cfg    = pwdata[1:0];
        default:          next_st.cfg    = st.cfg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.io_ctl    <= `C2PM_IO_CTL_RST;
      st.drive     <= `C2PM_DRIVE_RST;
      st.cfg       <= `C2PM_CFG_RST;
      st.prdata    <= 32'h0000_0000;
      st.err       <= 1'b0;
      st.line_sync <= 2'h0;
    end else begin
      st <= next_st;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access & st.err;
  assign prdata  = st.prdata;

  // Shared pin one: input on bus, general output otherwise
  assign add_bus_data_ch2_1_oe = (pin_fn == C2PM_FN_ALT);
  assign add_bus_data_ch2_1_o  = st.drive[`C2PM_GPO_BIT];

  // Add-bus domain, falling edge capture
  c2pm_add_st_t ast;
  c2pm_add_st_t next_ast;

  always_comb begin
    next_ast = ast;
    next_ast.en_sync = {ast.en_sync[0], st.cfg[`C2PM_CFG_BUS_EN_BIT]};
    next_ast.word_q  = 8'h00;
    if (ast.en_sync[1]) begin
      next_ast.word_q = {add_bus_data_ch2_hi,
                         add_bus_data_ch2_2,
                         add_bus_data_ch2_1_i,
                         add_bus_data_ch2_0};
    end
  end

  always_ff @(negedge add_bus_clock_ch2 or negedge presetn) begin
    if (!presetn) begin
      ast.en_sync <= 2'h0;
      ast.word_q  <= 8'h00;
    end else begin
      ast <= next_ast;
    end
  end

  assign add_bus_word_ch2 = ast.word_q;

  // Line clock domain
  c2pm_line_st_t lst;
  c2pm_line_st_t next_lst;
  logic          fall_q;
  logic          use_rise;

  always_ff @(negedge line_clock_in_ch2 or negedge presetn) begin
    if (!presetn) begin
      fall_q <= 1'b0;
    end else begin
      fall_q <= add_bus_data_ch2_2;
    end
  end

  assign use_rise = lst.inv_sync[1] & ~lst.sts1_sync[1];

  always_comb begin
    next_lst = lst;
    next_lst.en_sync   = {lst.en_sync[0], st.cfg[`C2PM_CFG_BUS_EN_BIT]};
    next_lst.inv_sync  = {lst.inv_sync[0], st.io_ctl[`C2PM_CLK_INV_BIT]};
    next_lst.sts1_sync = {lst.sts1_sync[0], st.cfg[`C2PM_CFG_STS1_BIT]};
    if (lst.en_sync[1]) begin
      next_lst.data_q = 1'b0;
    end else if (use_rise) begin
      next_lst.data_q = add_bus_data_ch2_2;
    end else begin
      next_lst.data_q = fall_q;
    end
  end

  always_ff @(posedge line_clock_in_ch2 or negedge presetn) begin
    if (!presetn) begin
      lst.en_sync   <= 2'h0;
      lst.inv_sync  <= 2'h0;
      lst.sts1_sync <= 2'h0;
      lst.data_q    <= 1'b0;
    end else begin
      lst <= next_lst;
    end
  end

  assign line_data_ch2 = lst.data_q;

  // Checks
  property p_bus_en_sel;
    @(posedge pclk) disable iff (!presetn)
      (wr && reg_idx == `C2PM_CFG_IDX) |=>
        (add_bus_data_ch2_1_oe == !$past(pwdata[`C2PM_CFG_BUS_EN_BIT]));
  endproperty
  a_bus_en_sel: assert property (p_bus_en_sel)
    else $error("pin one enable does not follow bus enable");

  property p_gpo_level;
    @(posedge pclk) disable iff (!presetn)
      !st.cfg[`C2PM_CFG_BUS_EN_BIT] |->
        (add_bus_data_ch2_1_oe && add_bus_data_ch2_1_o == st.drive[`C2PM_GPO_BIT]);
  endproperty
  a_gpo_level: assert property (p_gpo_level)
    else $error("general output not driven from register bit");

  property p_gpo_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && reg_idx == `C2PM_DRIVE_IDX) |=>
        (add_bus_data_ch2_1_o == $past(pwdata[`C2PM_GPO_BIT]));
  endproperty
  a_gpo_write: assert property (p_gpo_write)
    else $error("general output not updated after write");

  property p_apb_err;
    @(posedge pclk) disable iff (!presetn)
      (setup ##1 access) |-> (pslverr == !$past(hit) && pready);
  endproperty
  a_apb_err: assert property (p_apb_err)
    else $error("wrong error answer on access");

  property p_bit1;
    @(negedge add_bus_clock_ch2) disable iff (!presetn)
      ast.en_sync[1] |=> (add_bus_word_ch2[1] == $past(add_bus_data_ch2_1_i));
  endproperty
  a_bit1: assert property (p_bit1)
    else $error("add-bus bit 1 not taken from pin one");

  property p_bit2;
    @(negedge add_bus_clock_ch2) disable iff (!presetn)
      ast.en_sync[1] |=> (add_bus_word_ch2[2] == $past(add_bus_data_ch2_2));
  endproperty
  a_bit2: assert property (p_bit2)
    else $error("add-bus bit 2 not taken from pin two");

  property p_word_rest;
    @(negedge add_bus_clock_ch2) disable iff (!presetn)
      ast.en_sync[1] |=> (add_bus_word_ch2[7:3] == $past(add_bus_data_ch2_hi) &&
                          add_bus_word_ch2[0] == $past(add_bus_data_ch2_0));
  endproperty
  a_word_rest: assert property (p_word_rest)
    else $error("add-bus word not captured on falling edge");

  property p_line_fall;
    @(posedge line_clock_in_ch2) disable iff (!presetn)
      (!lst.en_sync[1] && !lst.inv_sync[1]) |=> (line_data_ch2 == $past(fall_q));
  endproperty
  a_line_fall: assert property (p_line_fall)
    else $error("line data not from falling edge sample");

  property p_line_rise;
    @(posedge line_clock_in_ch2) disable iff (!presetn)
      (!lst.en_sync[1] && lst.inv_sync[1] && !lst.sts1_sync[1]) |=>
        (line_data_ch2 == $past(add_bus_data_ch2_2));
  endproperty
  a_line_rise: assert property (p_line_rise)
    else $error("line data not from rising edge sample");

  property p_line_sts1;
    @(posedge line_clock_in_ch2) disable iff (!presetn)
      (!lst.en_sync[1] && lst.sts1_sync[1]) |=> (line_data_ch2 == $past(fall_q));
  endproperty
  a_line_sts1: assert property (p_line_sts1)
    else $error("STS-1 mode used rising edge");

endmodule

// ==== verilog/c2pm_map.svh ====
// Purpose: Offsets, field positions and reset values of the channel 2 pin mux
// Assumes: Register offsets are word indices; byte address is four times the index
// Notes:   Included by the pin mux module and the bench top
`ifndef C2PM_MAP_SVH
`define C2PM_MAP_SVH
`define C2PM_IO_CTL_IDX     16'h3f01
`define C2PM_DRIVE_IDX      16'h3f80
`define C2PM_CFG_IDX        16'h3f10
`define C2PM_STAT_IDX       16'h3f11
`define C2PM_CLK_INV_BIT    1
`define C2PM_GPO_BIT        5
`define C2PM_CFG_BUS_EN_BIT 0
`define C2PM_CFG_STS1_BIT   1
`define C2PM_IO_CTL_RST     8'h00
`define C2PM_DRIVE_RST      8'h00
`define C2PM_CFG_RST        2'h0
`define C2PM_MIN_ADDR_W     18
`endif

// ==== verilog/c2pm_pkg.sv ====
// Purpose: Types of the channel 2 pin mux
// Assumes: Constants come from c2pm_map.svh
// Notes:   One state struct per clock domain
package c2pm_pkg;

  typedef enum logic {
    C2PM_FN_BUS = 1'b0,
    C2PM_FN_ALT = 1'b1
  } c2pm_pin_fn_t;

  typedef struct packed {
    logic [7:0]  io_ctl;
    logic [7:0]  drive;
    logic [1:0]  cfg;
    logic [31:0] prdata;
    logic        err;
    logic [1:0]  line_sync;
  } c2pm_apb_st_t;

  typedef struct packed {
    logic [1:0] en_sync;
    logic [7:0] word_q;
  } c2pm_add_st_t;

  typedef struct packed {
    logic [1:0] en_sync;
    logic [1:0] inv_sync;
    logic [1:0] sts1_sync;
    logic       data_q;
  } c2pm_line_st_t;

endpackage

// ==== bench/c2pm_far_model.sv ====
// Purpose: Add-bus source and line unit model
// Assumes: Mode input picks which role drives pin two
// Notes:   Both link clocks run free
`timescale 1ns/100ps
module c2pm_far_model (
  input  wire logic       bus_mode,
  output logic            add_clk,
  output logic            line_clk,
  output logic      [7:0] add_d,
  output logic            pin2
);
  int   seed = 74798;
  logic line_bit = 1'b0;
  initial begin
    add_clk = 1'b0;
    #7;
    forever #20 add_clk = ~add_clk;
  end
  initial begin
    line_clk = 1'b0;
    #13;
    forever #32 line_clk = ~line_clk;
  end
  initial add_d = 8'h00;
  // Data moves on rising edge, steady at falling edge
  always @(posedge add_clk) add_d <= 8'($random(seed));
  // Moves mid low phase, so the two capture edges differ
  always @(negedge line_clk) line_bit <= #16 1'($random(seed));
  assign pin2 = bus_mode ? add_d[2] : line_bit;
endmodule

// ==== bench/c2pm_pin_mux_tb_top.sv ====
// Purpose: Self-checking bench of the channel 2 pin mux
// Assumes: Zero wait APB slave, far model on both links
// Notes:   Random data from a fixed seed
`timescale 1ns/100ps
`include "c2pm_map.svh"
module c2pm_pin_mux_tb_top;
  import c2pm_pkg::*;
  localparam logic [17:0] A_IO  = {`C2PM_IO_CTL_IDX, 2'b00};
  localparam logic [17:0] A_DRV = {`C2PM_DRIVE_IDX, 2'b00};
  localparam logic [17:0] A_CFG = {`C2PM_CFG_IDX, 2'b00};
  localparam logic [17:0] A_STA = {`C2PM_STAT_IDX, 2'b00};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, pin1_o, pin1_oe, pin1, line_q, add_clk, line_clk, pin2;
  logic [7:0]  word, add_d;
  logic        bus_mode = 0, mon_on = 0, inv = 0, sts = 0, fall_v = 0, rise_v;
  int          seed = 74798, num_errors = 0, total_checks = 0;
  assign pin1 = pin1_oe ? pin1_o : add_d[1];
  c2pm_pin_mux c2pm_pin_mux_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .add_bus_clock_ch2(add_clk), .add_bus_data_ch2_hi(add_d[7:3]),
    .add_bus_data_ch2_0(add_d[0]), .add_bus_data_ch2_1_i(pin1),
    .add_bus_data_ch2_1_o(pin1_o), .add_bus_data_ch2_1_oe(pin1_oe),
    .add_bus_data_ch2_2(pin2), .line_clock_in_ch2(line_clk),
    .add_bus_word_ch2(word), .line_data_ch2(line_q));
  c2pm_far_model c2pm_far_model_inst (
    .bus_mode(bus_mode), .add_clk(add_clk), .line_clk(line_clk), .add_d(add_d),
    .pin2(pin2));
  initial forever #25 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int   n;
    logic rdy;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      rdy = pready;
      r = prdata;
      e = pslverr;
    end while (rdy !== 1'b1 && n < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) chk("pready", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, s, r, e);
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 4'hf, r, e);
    chk("prdata", x, r);
    chk("pslverr", xe, e);
  endtask
  task automatic final_report;
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Expected line bit from the edge that the mode selects
  always @(negedge line_clk) fall_v <= pin2;
  always @(posedge line_clk) begin
    rise_v = pin2;
    #1;
    if (mon_on) chk("line", bus_mode ? 1'b0 : (inv & ~sts) ? rise_v : fall_v, line_q);
  end
  always @(negedge add_clk) begin
    logic [7:0] x;
    x = {add_d[7:3], pin2, pin1, add_d[0]};
    #1;
    if (mon_on) chk("add_word", bus_mode ? x : 8'h00, word);
  end
  initial begin
    int d;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_IO, 32'h0, 1'b0);
    rd(A_DRV, 32'h0, 1'b0);
    rd(A_CFG, 32'h0, 1'b0);
    chk("pin_oe", 32'h1, pin1_oe);
    rd(18'h00010, 32'h0, 1'b1);
    wr(18'h00010, 32'hff, 4'hf);
    repeat (6) begin
      d = $random(seed);
      wr(A_DRV, d, 4'hf);
      #1 chk("pin_out", d[5], pin1_o);
      rd(A_DRV, d & 32'hff, 1'b0);
    end
    wr(A_DRV, ~d, 4'he);
    #1 chk("pin_out", d[5], pin1_o);
    for (int m = 0; m < 6; m++) begin
      inv = m[0];
      sts = m[1];
      wr(A_IO, {m[0], 1'b0}, 4'hf);
      wr(A_CFG, {m[1], m[2]}, 4'hf);
      bus_mode <= m[2];
      #1 chk("pin_oe", !m[2], pin1_oe);
      repeat (10) @(posedge pclk);
      mon_on = 1'b1;
      repeat (120) @(posedge pclk);
      mon_on = 1'b0;
      if (m[2]) rd(A_STA, {29'h0, d[5], 2'b00}, 1'b0);
    end
    wr(A_CFG, 32'h0, 4'hf);
    bus_mode <= 1'b0;
    #1 chk("pin_out", {1'b1, d[5]}, {pin1_oe, pin1_o});
    final_report;
  end
  initial begin
    #400000;
    chk("watchdog", 32'h0, 32'h1);
    final_report;
  end
endmodule
